// File: logic/abe_alu_branch_execute.sv
`timescale 1ns/1ps
module abe_alu_branch_execute
  import abe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        opValid,
  input  wire abe_op_t     opCode,
  input  wire logic [7:0]  destData,
  input  wire logic [7:0]  srcData,
  input  wire logic [7:0]  immData,
  input  wire logic [2:0]  bitIndex,
  input  wire logic [7:0]  ioData,
  input  wire logic [11:0] relOffset,
  input  wire logic        nextTwoWord,
  output logic             opReady,
  output logic             busy,
  output logic             opDone,
  output logic [7:0]       resultData,
  output logic             resultWrite,
  output logic [8:0]       pcValue,
  output logic [7:0]       flagsValue,
  output logic             retPush,
  output logic [8:0]       retAddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);

  abe_regs_t  q;
  abe_regs_t  n;
  abe_alu_t   aluMode;
  logic [7:0] aluB;
  logic       aluCin;
  logic [7:0] aluRes;
  logic       aluC;
  logic       aluH;
  logic       aluV;
  logic       accept;
  logic       isArith;
  logic       isLogic;
  logic       writeBack;
  logic       chainZ;
  logic       isSkip;
  logic       isBranch;
  logic       cond;
  logic [8:0] relTarget;

  assign accept    = opValid & q.ready;
  assign relTarget = q.pc + relOffset[8:0] + ABE_STEP_NEXT;

  abe_alu_core u_alu (
    .opA       (destData),
    .opB       (aluB),
    .carryIn   (aluCin),
    .mode      (aluMode),
    .aluResult (aluRes),
    .carryOut  (aluC),
    .halfOut   (aluH),
    .ovfOut    (aluV)
  );

  // operation decode
  always_comb begin
    aluMode   = ABE_ALU_ADD;
    aluB      = srcData;
    aluCin    = 1'h0;
    isArith   = 1'h0;
    isLogic   = 1'h0;
    writeBack = 1'h0;
    chainZ    = 1'h0;
    isSkip    = 1'h0;
    isBranch  = 1'h0;
    cond      = 1'h0;
    case (opCode)
      ABE_OP_ADD, ABE_OP_ADD_CARRY: begin
        isArith   = 1'h1;
        writeBack = 1'h1;
        aluCin    = (opCode == ABE_OP_ADD_CARRY) & q.flags[ABE_FLAG_C];
      end
      ABE_OP_DIFF, ABE_OP_DIFF_IMM, ABE_OP_DIFF_BORROW, ABE_OP_DIFF_IMM_B,
      ABE_OP_CMP_REGS, ABE_OP_CMP_BORROW, ABE_OP_CMP_IMM: begin
        aluMode   = ABE_ALU_SUB;
        isArith   = 1'h1;
        writeBack = (opCode != ABE_OP_CMP_REGS) && (opCode != ABE_OP_CMP_BORROW) &&
                    (opCode != ABE_OP_CMP_IMM);
        chainZ    = (opCode == ABE_OP_DIFF_BORROW) || (opCode == ABE_OP_DIFF_IMM_B) ||
                    (opCode == ABE_OP_CMP_BORROW);
        aluCin    = chainZ & q.flags[ABE_FLAG_C];
        if ((opCode == ABE_OP_DIFF_IMM) || (opCode == ABE_OP_DIFF_IMM_B) ||
            (opCode == ABE_OP_CMP_IMM)) begin
          aluB = immData;
        end
      end
      ABE_OP_CONJ, ABE_OP_CONJ_IMM, ABE_OP_ZS_PROBE: begin
        aluMode = ABE_ALU_AND;
        aluB    = (opCode == ABE_OP_CONJ_IMM) ? immData :
                  (opCode == ABE_OP_ZS_PROBE) ? destData : srcData;
        isLogic = 1'h1;
        writeBack = 1'h1;
      end
      ABE_OP_DISJ, ABE_OP_DISJ_IMM, ABE_OP_MASK_HIGH: begin
        aluMode = ABE_ALU_OR;
        aluB    = (opCode == ABE_OP_DISJ) ? srcData : immData;
        isLogic = 1'h1;
        writeBack = 1'h1;
      end
      ABE_OP_MASK_LOW: begin
        aluMode = ABE_ALU_AND;
        aluB    = ABE_ALL_ONES - immData;
        isLogic = 1'h1;
        writeBack = 1'h1;
      end
      ABE_OP_XDISJ, ABE_OP_ZERO_FILL: begin
        aluMode = ABE_ALU_XOR;
        aluB    = (opCode == ABE_OP_ZERO_FILL) ? destData : srcData;
        isLogic = 1'h1;
        writeBack = 1'h1;
      end
      ABE_OP_EQ_SKIP: begin
        isSkip = 1'h1;
        cond   = (destData == srcData);
      end
      ABE_OP_SKIP_REG_LO, ABE_OP_SKIP_REG_HI: begin
        isSkip = 1'h1;
        cond   = destData[bitIndex] == (opCode == ABE_OP_SKIP_REG_HI);
      end
      ABE_OP_SKIP_IO_LO, ABE_OP_SKIP_IO_HI: begin
        isSkip = 1'h1;
        cond   = ioData[bitIndex] == (opCode == ABE_OP_SKIP_IO_HI);
      end
      ABE_OP_BR_STAT_HI, ABE_OP_BR_STAT_LO: begin
        isBranch = 1'h1;
        cond     = q.flags[bitIndex] == (opCode == ABE_OP_BR_STAT_HI);
      end
      ABE_OP_BR_EQUAL, ABE_OP_BR_UNEQUAL: begin
        isBranch = 1'h1;
        cond     = q.flags[ABE_FLAG_Z] == (opCode == ABE_OP_BR_EQUAL);
      end
      ABE_OP_BR_CARRY_HI, ABE_OP_BR_UNS_LT: begin
        isBranch = 1'h1;
        cond     = q.flags[ABE_FLAG_C];
      end
      ABE_OP_BR_CARRY_LO, ABE_OP_BR_UNS_GE: begin
        isBranch = 1'h1;
        cond     = ~q.flags[ABE_FLAG_C];
      end
      ABE_OP_BR_NEGATIVE, ABE_OP_BR_POSITIVE: begin
        isBranch = 1'h1;
        cond     = q.flags[ABE_FLAG_N] == (opCode == ABE_OP_BR_NEGATIVE);
      end
      ABE_OP_BR_SGN_GE, ABE_OP_BR_SGN_LT: begin
        isBranch = 1'h1;
        cond     = (q.flags[ABE_FLAG_N] ^ q.flags[ABE_FLAG_V]) ==
                   (opCode == ABE_OP_BR_SGN_LT);
      end
      ABE_OP_BR_HALF_HI, ABE_OP_BR_HALF_LO: begin
        isBranch = 1'h1;
        cond     = q.flags[ABE_FLAG_H] == (opCode == ABE_OP_BR_HALF_HI);
      end
      ABE_OP_BR_TBIT_HI, ABE_OP_BR_TBIT_LO: begin
        isBranch = 1'h1;
        cond     = q.flags[ABE_FLAG_T] == (opCode == ABE_OP_BR_TBIT_HI);
      end
      ABE_OP_BR_OVF_HI, ABE_OP_BR_OVF_LO: begin
        isBranch = 1'h1;
        cond     = q.flags[ABE_FLAG_V] == (opCode == ABE_OP_BR_OVF_HI);
      end
      ABE_OP_BR_IRQ_EN, ABE_OP_BR_IRQ_DIS: begin
        isBranch = 1'h1;
        cond     = q.flags[ABE_FLAG_I] == (opCode == ABE_OP_BR_IRQ_EN);
      end
      default: begin
        aluMode = ABE_ALU_ADD;
      end
    endcase
  end

  always_comb begin
    logic [1:0] clocks;
    clocks = ABE_CLK_SINGLE;
    n      = q;
    n.wrEn = 1'h0;
    n.done = 1'h0;
    n.push = 1'h0;
    // register bus: write side
    if (q.bValid && bready) begin
      n.bValid = 1'h0;
    end
    if (awvalid && q.awReady) begin
      n.awHeld = 1'h1;
      n.awAddr = awaddr;
    end
    if (wvalid && q.wReady) begin
      n.wHeld = 1'h1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (q.awHeld && q.wHeld && !q.bValid) begin
      n.awHeld = 1'h0;
      n.wHeld  = 1'h0;
      n.bValid = 1'h1;
      n.bResp  = ABE_RESP_OKAY;
      case (q.awAddr)
        ABE_OFF_CTRL:  if (q.wStrb[0]) n.runEn = q.wData[0];
        ABE_OFF_FLAGS: if (q.wStrb[0]) n.flags = q.wData[7:0];
        ABE_OFF_PC: begin
          if (q.wStrb[0]) n.pc[7:0] = q.wData[7:0];
          if (q.wStrb[1]) n.pc[8]   = q.wData[8];
        end
        ABE_OFF_COUNT: n.bResp = ABE_RESP_OKAY;
        default:       n.bResp = ABE_RESP_SLVERR;
      endcase
    end
    n.awReady = ~n.awHeld;
    n.wReady  = ~n.wHeld;
    // register bus: read side
    if (q.rValid && rready) begin
      n.rValid = 1'h0;
    end
    if (arvalid && q.arReady) begin
      n.rValid = 1'h1;
      n.rResp  = ABE_RESP_OKAY;
      case (araddr)
        ABE_OFF_CTRL:  n.rData = {31'h0000_0000, q.runEn};
        ABE_OFF_FLAGS: n.rData = {24'h00_0000, q.flags};
        ABE_OFF_PC:    n.rData = {23'h00_0000, q.pc};
        ABE_OFF_COUNT: n.rData = {16'h0000, q.opCount};
        default: begin
          n.rData = 32'h0000_0000;
          n.rResp = ABE_RESP_SLVERR;
        end
      endcase
    end
    n.arReady = ~n.rValid;
    // execution; wins over a bus write in the same cycle
    case (q.state)
      ABE_ST_IDLE: begin
        if (accept) begin
          n.opCount = q.opCount + 16'h0001;
          n.result  = aluRes;
          n.wrEn    = writeBack;
          if (isArith) begin
            n.flags[ABE_FLAG_C] = aluC;
            n.flags[ABE_FLAG_H] = aluH;
            n.flags[ABE_FLAG_V] = aluV;
            n.flags[ABE_FLAG_N] = aluRes[7];
            n.flags[ABE_FLAG_Z] = (aluRes == 8'h00) & (~chainZ | q.flags[ABE_FLAG_Z]);
            n.flags[ABE_FLAG_S] = aluRes[7] ^ aluV;
          end else if (isLogic) begin
            n.flags[ABE_FLAG_V] = 1'h0;
            n.flags[ABE_FLAG_N] = aluRes[7];
            n.flags[ABE_FLAG_Z] = (aluRes == 8'h00);
            n.flags[ABE_FLAG_S] = aluRes[7];
          end
          if ((opCode == ABE_OP_GOTO_REL) || (opCode == ABE_OP_SUBCALL_REL)) begin
            n.pc   = relTarget;
            clocks = (opCode == ABE_OP_GOTO_REL) ? ABE_CLK_GOTO : ABE_CLK_CALL;
            n.push = (opCode == ABE_OP_SUBCALL_REL);
            n.retAddr = q.pc + ABE_STEP_NEXT;
          end else if (isSkip && cond) begin
            n.pc   = q.pc + (nextTwoWord ? ABE_STEP_SKIP2 : ABE_STEP_SKIP1);
            clocks = ABE_CLK_TAKEN;
          end else if (isBranch && cond) begin
            n.pc   = relTarget;
            clocks = ABE_CLK_TAKEN;
          end else begin
            n.pc   = q.pc + ABE_STEP_NEXT;
          end
          if (clocks == ABE_CLK_SINGLE) begin
            n.done = 1'h1;
          end else begin
            n.state = ABE_ST_STALL;
            n.cnt   = clocks - 2'h2;
          end
        end
      end
      ABE_ST_STALL: begin
        if (q.cnt == 2'h0) begin
          n.state = ABE_ST_IDLE;
          n.done  = 1'h1;
        end else begin
          n.cnt = q.cnt - 2'h1;
        end
      end
      default: n.state = ABE_ST_IDLE;
    endcase
    n.busy  = (n.state == ABE_ST_STALL);
    n.ready = (n.state == ABE_ST_IDLE) & n.runEn;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.state   <= ABE_ST_IDLE;
      q.pc      <= ABE_PC_RESET;
      q.flags   <= ABE_FLAGS_RESET;
      q.runEn   <= ABE_CTRL_RESET;
      q.ready   <= ABE_CTRL_RESET;
      q.awReady <= ABE_READY_RESET;
      q.wReady  <= ABE_READY_RESET;
      q.arReady <= ABE_READY_RESET;
    end else begin
      q <= n;
    end
  end

  assign opReady     = q.ready;
  assign busy        = q.busy;
  assign opDone      = q.done;
  assign resultData  = q.result;
  assign resultWrite = q.wrEn;
  assign pcValue     = q.pc;
  assign flagsValue  = q.flags;
  assign retPush     = q.push;
  assign retAddr     = q.retAddr;
  assign awready     = q.awReady;
  assign wready      = q.wReady;
  assign bvalid      = q.bValid;
  assign bresp       = q.bResp;
  assign arready     = q.arReady;
  assign rvalid      = q.rValid;
  assign rdata       = q.rData;
  assign rresp       = q.rResp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  add_result_a: assert property (
    accept && opCode == ABE_OP_ADD |=> resultWrite && opDone &&
      resultData == 8'($past(destData) + $past(srcData)))
    else $error("add result wrong");
  sub_carry_a: assert property (
    accept && opCode == ABE_OP_DIFF |=>
      flagsValue[ABE_FLAG_C] == ($past(destData) < $past(srcData)))
    else $error("subtract borrow wrong");
  logic_keeps_a: assert property (
    accept && (opCode == ABE_OP_CONJ || opCode == ABE_OP_XDISJ) |=>
      flagsValue[ABE_FLAG_C] == $past(flagsValue[ABE_FLAG_C]) &&
      flagsValue[ABE_FLAG_H] == $past(flagsValue[ABE_FLAG_H]) && !flagsValue[ABE_FLAG_V])
    else $error("logic op touched carry");
  mask_low_a: assert property (
    accept && opCode == ABE_OP_MASK_LOW |=> resultData == ($past(destData) & ~$past(immData)))
    else $error("mask low wrong");
  goto_time_a: assert property (
    accept && opCode == ABE_OP_GOTO_REL |=> busy && !opDone ##1 opDone && !busy)
    else $error("relative goto timing wrong");
  call_time_a: assert property (
    accept && opCode == ABE_OP_SUBCALL_REL |=> retPush ##0 !opDone [*2] ##1 opDone)
    else $error("relative subcall timing wrong");
  cmp_nowrite_a: assert property (
    accept && opCode == ABE_OP_CMP_REGS |=> !resultWrite &&
      flagsValue[ABE_FLAG_Z] == ($past(destData) == $past(srcData)))
    else $error("compare wrote result");
  skip_step_a: assert property (
    accept && opCode == ABE_OP_EQ_SKIP && destData == srcData && nextTwoWord |=>
      pcValue == 9'($past(pcValue) + 9'h003) && flagsValue == $past(flagsValue) ##1 opDone)
    else $error("equal skip step wrong");
  untaken_one_a: assert property (
    accept && (isBranch || isSkip) && !cond |=> opDone &&
      pcValue == 9'($past(pcValue) + 9'h001))
    else $error("untaken branch not one clock");
  signed_ge_a: assert property (
    accept && opCode == ABE_OP_BR_SGN_GE && !(q.flags[ABE_FLAG_N] ^ q.flags[ABE_FLAG_V]) |=>
      pcValue == 9'($past(pcValue) + $past(relOffset[8:0]) + 9'h001))
    else $error("signed branch target wrong");
  half_carry_a: assert property (
    accept && opCode == ABE_OP_ADD |=>
      flagsValue[ABE_FLAG_H] == (($past(destData[3:0]) + $past(srcData[3:0])) > 15))
    else $error("half carry wrong");

  taken_cv: cover property (accept && isBranch && cond ##2 opDone);
  call_cv: cover property (accept && opCode == ABE_OP_SUBCALL_REL ##3 opDone);
  bus_write_cv: cover property (bvalid && bready && bresp == ABE_RESP_OKAY);

endmodule

// File: logic/abe_pkg.sv
package abe_pkg;

  localparam int                ABE_PC_W        = 9;
  localparam logic [8:0]        ABE_PC_RESET    = 9'h000;
  localparam logic [7:0]        ABE_FLAGS_RESET = 8'h00;
  localparam logic [7:0]        ABE_ALL_ONES    = 8'hff;

  // status_flags_register bit positions
  localparam int                ABE_FLAG_C      = 0;
  localparam int                ABE_FLAG_Z      = 1;
  localparam int                ABE_FLAG_N      = 2;
  localparam int                ABE_FLAG_V      = 3;
  localparam int                ABE_FLAG_S      = 4;
  localparam int                ABE_FLAG_H      = 5;
  localparam int                ABE_FLAG_T      = 6;
  localparam int                ABE_FLAG_I      = 7;

  // cycle counts and program counter steps
  localparam logic [1:0]        ABE_CLK_SINGLE  = 2'h1;
  localparam logic [1:0]        ABE_CLK_TAKEN   = 2'h2;
  localparam logic [1:0]        ABE_CLK_GOTO    = 2'h2;
  localparam logic [1:0]        ABE_CLK_CALL    = 2'h3;
  localparam logic [8:0]        ABE_STEP_NEXT   = 9'h001;
  localparam logic [8:0]        ABE_STEP_SKIP1  = 9'h002;
  localparam logic [8:0]        ABE_STEP_SKIP2  = 9'h003;

  // register bus map
  localparam int                ABE_ADDR_W      = 4;
  localparam logic [3:0]        ABE_OFF_CTRL    = 4'h0;
  localparam logic [3:0]        ABE_OFF_FLAGS   = 4'h4;
  localparam logic [3:0]        ABE_OFF_PC      = 4'h8;
  localparam logic [3:0]        ABE_OFF_COUNT   = 4'hc;
  localparam logic              ABE_CTRL_RESET  = 1'h1;
  localparam logic              ABE_READY_RESET = 1'h1;
  localparam logic [1:0]        ABE_RESP_OKAY   = 2'h0;
  localparam logic [1:0]        ABE_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ABE_ALU_ADD = 3'h0,
    ABE_ALU_SUB = 3'h1,
    ABE_ALU_AND = 3'h2,
    ABE_ALU_OR  = 3'h3,
    ABE_ALU_XOR = 3'h4
  } abe_alu_t;

  typedef enum logic [0:0] {
    ABE_ST_IDLE  = 1'h0,
    ABE_ST_STALL = 1'h1
  } abe_state_t;

  typedef enum logic [5:0] {
    ABE_OP_NOP        = 6'h00, ABE_OP_ADD         = 6'h01, ABE_OP_ADD_CARRY  = 6'h02,
    ABE_OP_DIFF       = 6'h03, ABE_OP_DIFF_IMM    = 6'h04, ABE_OP_DIFF_BORROW = 6'h05,
    ABE_OP_DIFF_IMM_B = 6'h06, ABE_OP_CONJ        = 6'h07, ABE_OP_CONJ_IMM   = 6'h08,
    ABE_OP_DISJ       = 6'h09, ABE_OP_DISJ_IMM    = 6'h0a, ABE_OP_XDISJ      = 6'h0b,
    ABE_OP_MASK_HIGH  = 6'h0c, ABE_OP_MASK_LOW    = 6'h0d, ABE_OP_ZS_PROBE   = 6'h0e,
    ABE_OP_ZERO_FILL  = 6'h0f, ABE_OP_GOTO_REL    = 6'h10, ABE_OP_SUBCALL_REL = 6'h11,
    ABE_OP_EQ_SKIP    = 6'h12, ABE_OP_CMP_REGS    = 6'h13, ABE_OP_CMP_BORROW = 6'h14,
    ABE_OP_CMP_IMM    = 6'h15, ABE_OP_SKIP_REG_LO = 6'h16, ABE_OP_SKIP_REG_HI = 6'h17,
    ABE_OP_SKIP_IO_LO = 6'h18, ABE_OP_SKIP_IO_HI  = 6'h19, ABE_OP_BR_STAT_HI = 6'h1a,
    ABE_OP_BR_STAT_LO = 6'h1b, ABE_OP_BR_EQUAL    = 6'h1c, ABE_OP_BR_UNEQUAL = 6'h1d,
    ABE_OP_BR_CARRY_HI = 6'h1e, ABE_OP_BR_CARRY_LO = 6'h1f, ABE_OP_BR_UNS_GE = 6'h20,
    ABE_OP_BR_UNS_LT  = 6'h21, ABE_OP_BR_NEGATIVE = 6'h22, ABE_OP_BR_POSITIVE = 6'h23,
    ABE_OP_BR_SGN_GE  = 6'h24, ABE_OP_BR_SGN_LT   = 6'h25, ABE_OP_BR_HALF_HI = 6'h26,
    ABE_OP_BR_HALF_LO = 6'h27, ABE_OP_BR_TBIT_HI  = 6'h28, ABE_OP_BR_TBIT_LO = 6'h29,
    ABE_OP_BR_OVF_HI  = 6'h2a, ABE_OP_BR_OVF_LO   = 6'h2b, ABE_OP_BR_IRQ_EN  = 6'h2c,
    ABE_OP_BR_IRQ_DIS = 6'h2d
  } abe_op_t;

  typedef struct packed {
    abe_state_t  state;
    logic [1:0]  cnt;
    logic        ready;
    logic        busy;
    logic [8:0]  pc;
    logic [7:0]  flags;
    logic [7:0]  result;
    logic        wrEn;
    logic        done;
    logic        push;
    logic [8:0]  retAddr;
    logic        runEn;
    logic [15:0] opCount;
    logic        awReady;
    logic        awHeld;
    logic [3:0]  awAddr;
    logic        wReady;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } abe_regs_t;

endpackage

// File: logic/abe_alu_core.sv
`timescale 1ns/1ps
module abe_alu_core
  import abe_pkg::*;
(
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  input  wire logic       carryIn,
  input  wire abe_alu_t   mode,
  output logic      [7:0] aluResult,
  output logic            carryOut,
  output logic            halfOut,
  output logic            ovfOut
);

  logic [8:0] wide;

  always_comb begin
    wide      = 9'h000;
    aluResult = 8'h00;
    carryOut  = 1'h0;
    halfOut   = 1'h0;
    ovfOut    = 1'h0;
    case (mode)
      ABE_ALU_ADD: begin
        wide      = {1'h0, opA} + {1'h0, opB} + {8'h00, carryIn};
        aluResult = wide[7:0];
        carryOut  = wide[8];
        halfOut   = (opA[3] & opB[3]) | (opB[3] & ~aluResult[3]) | (~aluResult[3] & opA[3]);
        ovfOut    = (opA[7] & opB[7] & ~aluResult[7]) | (~opA[7] & ~opB[7] & aluResult[7]);
      end
      ABE_ALU_SUB: begin
        wide      = {1'h0, opA} - {1'h0, opB} - {8'h00, carryIn};
        aluResult = wide[7:0];
        carryOut  = wide[8];
        halfOut   = (~opA[3] & opB[3]) | (opB[3] & aluResult[3]) | (aluResult[3] & ~opA[3]);
        ovfOut    = (opA[7] & ~opB[7] & ~aluResult[7]) | (~opA[7] & opB[7] & aluResult[7]);
      end
      ABE_ALU_AND: aluResult = opA & opB;
      ABE_ALU_OR:  aluResult = opA | opB;
      ABE_ALU_XOR: aluResult = opA ^ opB;
      default:     aluResult = 8'h00;
    endcase
  end

endmodule

// File: tb/abe_dec_model.sv
`timescale 1ns/1ps
module abe_dec_model
  import abe_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   opReady,
  input  wire logic   opDone,
  output logic        opValid,
  output abe_op_t     opCode,
  output logic [7:0]  destData,
  output logic [7:0]  srcData,
  output logic [7:0]  immData,
  output logic [2:0]  bitIndex,
  output logic [7:0]  ioData,
  output logic [11:0] relOffset,
  output logic        nextTwoWord
);
  initial begin
    opCode = ABE_OP_NOP;
    {opValid, destData, srcData, immData, bitIndex, ioData, relOffset, nextTwoWord} = '0;
  end
  // hold until taken, then scramble released operands
  task automatic issue(input logic [5:0] o, input logic [7:0] d, s, k, input logic [2:0] b,
                       input logic [11:0] f, input logic w, output int n);
    @(posedge clk);
    opCode <= abe_op_t'(o);
    {opValid, destData, srcData, immData, ioData, bitIndex, relOffset, nextTwoWord} <=
      {1'b1, d, s, k, d, b, f, w};
    do @(negedge clk); while (opReady !== 1'b1);
    @(posedge clk);
    opValid <= 1'b0;
    {destData, srcData, immData, ioData} <= ~{d, s, k, d};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (opDone !== 1'b1 && n < 8);
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb
  import abe_pkg::*;
;
  logic        clk, rst, opValid, nextTwoWord, opReady, busy, opDone, resultWrite, retPush, t;
  abe_op_t     opCode;
  logic [7:0]  destData, srcData, immData, ioData, resultData, flagsValue;
  logic [2:0]  bitIndex;
  logic [11:0] relOffset, off;
  logic [8:0]  pcValue, retAddr, expPc, expRet;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rr;
  int          num_errors = 0, n_checks = 0, cyc = 0, clks;
  int          busyCnt = 0, pushCnt = 0, expBusy = 0;
  // preset flags, op, dest, src, imm, result, flags
  logic [55:0] alu [19] = '{56'h00010f01001020, 56'h00018080000000 | 56'h1b, 56'h01020101000300,
    56'h00030001000000 | 56'hff35, 56'h35050100000000, 56'h00150500070035, 56'h2107f080008035,
    56'h210dff000ff035, 56'h210f5a00000023, 56'h000c0100808114, 56'h00041000010f20,
    56'h000e8000008014, 56'h210bff0f00f035, 56'h03140504000002, 56'h000a0000000002,
    56'h010610000f0020, 56'h0008ff00000002, 56'h00094020006000, 56'h00133333000002};
  // op, dest, src, bit, two-word
  logic [31:0] sk [8] = '{32'h12333300, 32'h12333301, 32'h12333400, 32'h16040021,
    32'h16fb0021, 32'h17040020, 32'h18800070, 32'h19800071};
  logic [7:0]  fl [3] = '{8'h00, 8'hff, 8'h04};
  abe_dec_model dec (.clk, .opReady, .opDone, .opValid, .opCode, .destData, .srcData, .immData,
    .bitIndex, .ioData, .relOffset, .nextTwoWord);
  abe_alu_branch_execute uut (.clk, .rst, .opValid, .opCode, .destData, .srcData, .immData,
    .bitIndex, .ioData, .relOffset, .nextTwoWord, .opReady, .busy, .opDone, .resultData,
    .resultWrite, .pcValue, .flagsValue, .retPush, .retAddr, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  // stall cycles and return pushes, sampled mid-cycle
  always @(negedge clk) begin
    busyCnt += busy;
    pushCnt += retPush;
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, a, d};
    fork
      begin
        do @(negedge clk); while (awready !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0;
      end
      begin
        do @(negedge clk); while (wready !== 1'b1);
        @(posedge clk);
        wvalid <= 1'b0;
      end
    join
    do @(negedge clk); while (bvalid !== 1'b1);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    @(posedge clk);
    {arvalid, rready, araddr} <= {2'h3, a};
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    {rd, rr} = {rdata, rresp};
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic run(input logic [5:0] o, input logic [7:0] d, s, k, input logic [2:0] b,
                     input logic [11:0] f, input logic w, input logic [8:0] adv, input int n);
    dec.issue(o, d, s, k, b, f, w, clks);
    expPc = expPc + adv;
    expBusy += n - 1;
    chk("cycles", clks, n);
    chk("pc", pcValue, expPc);
  endtask
  function automatic logic tk(input logic [5:0] o, input logic [7:0] f, d, s,
                              input logic [2:0] b);
    logic v;
    case (o[5:1])
      5'h09: v = d == s;
      5'h0b, 5'h0c: v = !d[b];
      5'h0d: v = f[b];
      5'h0e: v = f[1];
      5'h0f: v = f[0];
      5'h10: v = !f[0];
      5'h11: v = f[2];
      5'h12: v = !(f[2] ^ f[3]);
      5'h13: v = f[5];
      5'h14: v = f[6];
      5'h15: v = f[3];
      default: v = f[7];
    endcase
    return o[0] ? !v : v;
  endfunction
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    rst = 1'b1;
    expPc = 9'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    axr(ABE_OFF_CTRL);
    chk("ctrl", rd, 32'h1);
    chk("ready", opReady, 1'b1);
    $display("reset test done");
    foreach (alu[i]) begin
      axw(ABE_OFF_FLAGS, {24'h0, alu[i][55:48]});
      run(alu[i][45:40], alu[i][39:32], alu[i][31:24], alu[i][23:16], 3'h0, 12'h0, 1'b0,
          9'h1, 1);
      t = alu[i][45:40] < 6'h13;
      chk("write", resultWrite, t);
      if (t) chk("result", resultData, alu[i][15:8]);
      chk("flags", flagsValue, alu[i][7:0]);
    end
    $display("alu test done");
    foreach (fl[j]) begin
      axw(ABE_OFF_FLAGS, {24'h0, fl[j]});
      for (int o = 26; o <= 45; o++) begin
        t = tk(6'(o), fl[j], 8'h0, 8'h0, 3'(o));
        off = o[0] ? 12'hffd : 12'h004;
        run(6'(o), 8'h0, 8'h0, 8'h0, 3'(o), off, 1'b0, t ? off[8:0] + 9'h1 : 9'h1, t ? 2 : 1);
        chk("flags", flagsValue, fl[j]);
      end
    end
    $display("branch test done");
    foreach (sk[i]) begin
      t = tk(sk[i][29:24], 8'h0, sk[i][23:16], sk[i][15:8], sk[i][6:4]);
      run(sk[i][29:24], sk[i][23:16], sk[i][15:8], 8'h0, sk[i][6:4], 12'h0, sk[i][0],
          t ? (sk[i][0] ? 9'h3 : 9'h2) : 9'h1, t ? 2 : 1);
      chk("flags", flagsValue, 8'h04);
    end
    $display("skip test done");
    axw(ABE_OFF_PC, 32'h1f0);
    expPc = 9'h1f0;
    run(6'h10, 8'h0, 8'h0, 8'h0, 3'h0, 12'h0ff, 1'b0, 9'h100, 2);
    expRet = expPc + 9'h1;
    run(6'h11, 8'h0, 8'h0, 8'h0, 3'h0, 12'hf00, 1'b0, 9'h101, 3);
    chk("ret", retAddr, expRet);
    chk("busy", busyCnt, expBusy);
    chk("push", pushCnt, 1);
    axr(ABE_OFF_COUNT);
    chk("count", rd, 32'h59);
    axr(4'h2);
    chk("resp", rr, ABE_RESP_SLVERR);
    $display("jump and bus test done");
    print_verdict();
  end
endmodule
